// >>> pkg/converter_regs.vh
// Purpose: Register map, field positions, reset values and timing counts
//          for the successive-approximation converter control logic.
// Assumes: 8-bit register port, 2-bit register index.
// Notes:   Definitions only; included by bare name.
`ifndef CONVERTER_REGS_VH
`define CONVERTER_REGS_VH

// Register indexes
`define ADDR_STATUS_CONTROL   2'h0
`define ADDR_RESULT_HIGH      2'h1
`define ADDR_RESULT_LOW       2'h2
`define ADDR_CLOCK_CONFIG     2'h3

// Status and control fields
`define SC_FLAG_BIT           7
`define SC_IRQ_EN_BIT         6
`define SC_CONT_BIT           5
`define SC_CHAN_MSB           4
`define SC_CHAN_LSB           0

// Clock configuration fields
`define CC_DIV_MSB            7
`define CC_DIV_LSB            5
`define CC_ICS_BIT            4
`define CC_MODE_MSB           3
`define CC_MODE_LSB           2

// Reset values
`define RST_CHANNEL           5'h1f
`define RST_DIV               3'h0
`define RST_ICS               1'b0
`define RST_MODE              2'h1

// Channel codes
`define CHAN_PORT_LAST        5'h06
`define CHAN_FACTORY_TEST     5'h1b
`define CHAN_HIGH_REF         5'h1d
`define CHAN_GROUND           5'h1e
`define CHAN_POWER_OFF        5'h1f

// Justification codes
`define MODE_TRUNC8           2'h0
`define MODE_RIGHT            2'h1
`define MODE_LEFT             2'h2
`define MODE_LEFT_SIGNED      2'h3

// Timing in converter clock periods; prescaler count in input clock ticks
`define CONV_LAST_CYCLE       4'hf
`define SAMPLE_LAST_CYCLE     4'h5
`define DIV_BY_16             4'hf

`endif

// >>> hdl/sar_adc_control_logic.v
// Purpose: Control, timing and result formatting for a 10-bit
//          successive-approximation converter behind a byte register port.
// Assumes: clk is the 40 MHz bus clock; crystal_clock and comparator_out
//          arrive from other domains and are synchronised here.
// Notes:   Function
// Function
// - Interrupt request at end of each conversion
// - Request withdrawn on result read or control write
// - Flag read-only, set on completion, irq disabled
// - Flag clears on control write or result read
// - Irq enabled: flag writable, irq only when zero
// - Runs in wait; request wakes processor
// - Stop aborts conversion; resume after stop exit
// - Control write aborts and restarts conversion
// - Continuous bit converts back to back
// - Five-bit channel select drives input multiplexer
// - All-ones channel code powers converter off
// - High read freezes low until read
// - Left format: high eight bits, low two
// - Right format: high two bits, low eight
// - Truncation: low holds upper eight, no interlock
// - Prescaler divides by 1,2,4,8, else 16
// - Clock select: one bus, zero crystal
// - Two-bit justification select, reset right-justified
// - Reset clears enable, continuous and flag
// - Signed left format inverts top result bit
// - Conversion takes 16 to 17 converter periods; this design takes at most 16
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "converter_regs.vh"

module sar_adc_control_logic (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [1:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  input  wire        crystal_clock,
  input  wire        comparator_out,
  input  wire        stop_mode,
  output reg         irq_request,
  output reg  [4:0]  analog_mux_select,
  output reg         analog_power_down,
  output reg  [9:0]  sar_trial_code,
  output reg         sample_enable
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_CONV = 2'b10;

  // Result byte formatting, shared by the high and low read paths
  // Applied at read time, so a mode change reformats the stored result
  function [7:0] format_byte;
    input [9:0] res;
    input [1:0] mode;
    input       high_sel;
    begin
      case (mode)
        // truncation places upper eight bits low
        `MODE_TRUNC8: format_byte = high_sel ? 8'h00 : res[9:2];
        `MODE_RIGHT: format_byte = high_sel ? {6'h00, res[9:8]} : res[7:0];
        `MODE_LEFT: format_byte = high_sel ? res[9:2] : {res[1:0], 6'h00};
        // signed format inverts top result bit
        `MODE_LEFT_SIGNED: format_byte = high_sel ?
          {~res[9], res[8:2]} : {res[1:0], 6'h00};
        default: format_byte = 8'h00;
      endcase
    end
  endfunction

  // Prescaler terminal count for the selected divide ratio
  // Every code with the top bit set divides by sixteen
  function [3:0] div_terminal;
    input [2:0] code;
    begin
      case (code)
        3'h0:    div_terminal = 4'h0;
        3'h1:    div_terminal = 4'h1;
        3'h2:    div_terminal = 4'h3;
        3'h3:    div_terminal = 4'h7;
        default: div_terminal = `DIV_BY_16;
      endcase
    end
  endfunction

  // Control and configuration state
  reg        flag_reg;
  reg        irq_en_reg;
  reg        cont_reg;
  reg  [4:0] channel_reg;
  reg  [2:0] div_reg;
  reg        ics_reg;
  reg  [1:0] mode_reg;

  // Conversion state
  reg  [1:0] state_reg;
  reg  [3:0] cycle_reg;
  reg  [3:0] pre_cnt_reg;
  reg  [9:0] result_reg;
  reg        lock_reg;
  reg        stop_d_reg;
  reg        resume_reg;
  reg        xtal_d_reg;

  // Two-stage synchronisers for the crystal clock and the comparator
  wire [1:0] async_in = {comparator_out, crystal_clock};
  wire [1:0] sync_out;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
      // Each stage pair is private, so no vector has two drivers
      reg stage1_reg;
      reg stage2_reg;
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end else begin
          stage1_reg <= async_in[gi];
          stage2_reg <= stage1_reg;
        end
      end
      assign sync_out[gi] = stage2_reg;
    end
  endgenerate

  wire comp_s  = sync_out[1];
  wire xtal_s  = sync_out[0];

  // Access decode
  wire wr_ctrl   = reg_write && (reg_addr == `ADDR_STATUS_CONTROL);
  wire wr_clk    = reg_write && (reg_addr == `ADDR_CLOCK_CONFIG);
  wire rd_high   = reg_read  && (reg_addr == `ADDR_RESULT_HIGH);
  wire rd_low    = reg_read  && (reg_addr == `ADDR_RESULT_LOW);
  wire rd_result = rd_high || rd_low;

  // all-ones channel code means powered off
  wire powered_off = (channel_reg == `CHAN_POWER_OFF);
  wire new_off     = (reg_wdata[`SC_CHAN_MSB:`SC_CHAN_LSB] ==
                      `CHAN_POWER_OFF);

  // one selects bus clock, zero the crystal clock edge
  wire in_tick = ics_reg ? 1'b1 : (xtal_s && !xtal_d_reg);

  // prescaler terminal count produces one converter tick
  wire adc_tick = in_tick && (pre_cnt_reg >= div_terminal(div_reg));

  wire busy       = (state_reg == ST_CONV);
  wire stop_exit  = stop_d_reg && !stop_mode;

  // sixteenth tick after start ends the conversion
  wire conv_done  = busy && adc_tick && !stop_mode && !wr_ctrl &&
                    (cycle_reg == `CONV_LAST_CYCLE);

  // Bit under trial in the approximation phase
  // The comparator is two synchroniser stages late, so a converter
  // tick must span three bus clocks or more for a trial to settle
  wire [3:0] trial_idx = `CONV_LAST_CYCLE - cycle_reg;
  wire [9:0] trial_bit = 10'h001 << trial_idx;
  wire [9:0] decided   = comp_s ? sar_trial_code
                                : (sar_trial_code & ~trial_bit);

  // a pending high read holds off new results, except truncation
  // Results that finish while locked are dropped, never queued
  wire store_ok = !(lock_reg && (mode_reg != `MODE_TRUNC8));

  // Register writes and the completion flag
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // reset clears enable, continuous and flag
      flag_reg    <= 1'b0;
      irq_en_reg  <= 1'b0;
      cont_reg    <= 1'b0;
      channel_reg <= `RST_CHANNEL;
      div_reg     <= `RST_DIV;
      ics_reg     <= `RST_ICS;
      mode_reg    <= `RST_MODE;
    end else begin
      if (wr_ctrl) begin
        irq_en_reg  <= reg_wdata[`SC_IRQ_EN_BIT];
        cont_reg    <= reg_wdata[`SC_CONT_BIT];
        channel_reg <= reg_wdata[`SC_CHAN_MSB:`SC_CHAN_LSB];
      end
      if (wr_clk) begin
        div_reg  <= reg_wdata[`CC_DIV_MSB:`CC_DIV_LSB];
        ics_reg  <= reg_wdata[`CC_ICS_BIT];
        mode_reg <= reg_wdata[`CC_MODE_MSB:`CC_MODE_LSB];
      end
      // Set wins over clear so a completion is never lost
      if (conv_done && !irq_en_reg) begin
        // set on completion while interrupts are off
        flag_reg <= 1'b1;
      end else if (wr_ctrl && reg_wdata[`SC_IRQ_EN_BIT]) begin
        // flag becomes a writable target select
        flag_reg <= reg_wdata[`SC_FLAG_BIT];
      end else if (wr_ctrl || (rd_result && !irq_en_reg)) begin
        // clear on control write or result read
        flag_reg <= 1'b0;
      end
    end
  end

  // Interrupt request
  // Set wins over clear, so a completion beside a read is not lost
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_request <= 1'b0;
    end else if (conv_done && irq_en_reg && !flag_reg) begin
      // only while target select holds zero
      // the same request wakes the processor from wait
      irq_request <= 1'b1;
    end else if (wr_ctrl || rd_result) begin
      // withdrawn on result read or control write
      irq_request <= 1'b0;
    end
  end

  // Crystal edge detector and stop tracking
  // The detector resets low like the synchronised level: no false tick
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xtal_d_reg <= 1'b0;
      stop_d_reg <= 1'b0;
    end else begin
      xtal_d_reg <= xtal_s;
      stop_d_reg <= stop_mode;
    end
  end

  // Conversion sequencer: sample, then ten trials, one per tick
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg      <= ST_IDLE;
      cycle_reg      <= 4'h0;
      pre_cnt_reg    <= 4'h0;
      sar_trial_code <= 10'h000;
      sample_enable  <= 1'b0;
      resume_reg     <= 1'b0;
    end else begin
      if (stop_mode) begin
        // stop abandons the conversion, resumes on exit
        // A live or continuous run is remembered for the restart
        if (busy || cont_reg) begin
          resume_reg <= 1'b1;
        end
        state_reg     <= ST_IDLE;
        sample_enable <= 1'b0;
        pre_cnt_reg   <= 4'h0;
      end else if (wr_ctrl) begin
        resume_reg     <= 1'b0;
        pre_cnt_reg    <= 4'h0;
        cycle_reg      <= 4'h0;
        sar_trial_code <= 10'h000;
        // The off code leaves the sequencer idle
        if (new_off) begin
          state_reg     <= ST_IDLE;
          sample_enable <= 1'b0;
        end else begin
          state_reg     <= ST_CONV;
          sample_enable <= 1'b1;
        end
      end else if (stop_exit && resume_reg && !powered_off) begin
        resume_reg     <= 1'b0;
        state_reg      <= ST_CONV;
        cycle_reg      <= 4'h0;
        pre_cnt_reg    <= 4'h0;
        sar_trial_code <= 10'h000;
        sample_enable  <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            pre_cnt_reg   <= 4'h0;
            sample_enable <= 1'b0;
          end
          ST_CONV: begin
            // First tick may be partial: 15 to 16 periods overall
            if (in_tick) begin
              pre_cnt_reg <= adc_tick ? 4'h0 : pre_cnt_reg + 4'h1;
            end
            if (adc_tick) begin
              cycle_reg <= cycle_reg + 4'h1;
              if (cycle_reg == `SAMPLE_LAST_CYCLE) begin
                sample_enable  <= 1'b0;
                sar_trial_code <= 10'h200;
              end else if (cycle_reg > `SAMPLE_LAST_CYCLE) begin
                sar_trial_code <= decided | (trial_bit >> 1);
              end
              if (cycle_reg == `CONV_LAST_CYCLE) begin
                cycle_reg <= 4'h0;
                sar_trial_code <= 10'h000;
                // continuous restarts at once, single stops
                if (cont_reg && !powered_off) begin
                  sample_enable <= 1'b1;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Result store and read interlock
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= 10'h000;
      lock_reg   <= 1'b0;
    end else begin
      if (conv_done && store_ok) begin
        result_reg <= decided;
      end
      // high read freezes low, low read releases
      if (rd_low) begin
        lock_reg <= 1'b0;
      end else if (rd_high && (mode_reg != `MODE_TRUNC8)) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped bits read zero
  // Zero outside the answer slot, so no stale byte lingers on the bus
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        `ADDR_STATUS_CONTROL:
          reg_rdata <= {flag_reg, irq_en_reg, cont_reg, channel_reg};
        `ADDR_RESULT_HIGH:
          reg_rdata <= format_byte(result_reg, mode_reg, 1'b1);
        `ADDR_RESULT_LOW:
          reg_rdata <= format_byte(result_reg, mode_reg, 1'b0);
        `ADDR_CLOCK_CONFIG:
          reg_rdata <= {div_reg, ics_reg, mode_reg, 2'h0};
        default:
          reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Analog side: channel to the multiplexer, power down when off
  // Both follow the control register one cycle late
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      analog_mux_select <= `RST_CHANNEL;
      analog_power_down <= 1'b1;
    end else begin
      // channel code passes to the input multiplexer
      analog_mux_select <= channel_reg;
      // powered off for all-ones code or in stop
      analog_power_down <= powered_off || stop_mode;
    end
  end

endmodule

// >>> sim/adc_ctrl_sva.sv
// Purpose: Port-level assertions for the converter control block
// Assumes: Bench never writes an off code while a sample is running
// Notes:   Bound to the design from tb
`timescale 1ns/1ps
module adc_ctrl_sva (
  input wire       clk,
  input wire       reset_n,
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire [7:0] reg_rdata,
  input wire       stop_mode,
  input wire       irq_request,
  input wire [4:0] analog_mux_select,
  input wire       analog_power_down,
  input wire [9:0] sar_trial_code,
  input wire       sample_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A control write, which also starts a conversion unless it writes the off code or stop is set
  sequence ctrl_wr;
    reg_write && reg_addr == 2'h0;
  endsequence
  sequence stopped2;
    stop_mode [*2];
  endsequence
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_stop_off: assert property (stop_mode |=> analog_power_down)
    else $error("stop left converter powered");
  a_stop_idle: assert property (stopped2 |-> !sample_enable)
    else $error("sampling during stop");
  a_irq_clear: assert property (
    (reg_write && reg_addr == 2'h0 || reg_read && ^reg_addr)
    |=> !irq_request) else $error("request not withdrawn");
  a_conv_start: assert property (
    ctrl_wr ##0 (reg_wdata[4:0] != 5'h1f && !stop_mode) |=> sample_enable)
    else $error("write did not start conversion");
  a_sample_len: assert property (
    disable iff (!reset_n || stop_mode || reg_write)
    $rose(sample_enable) |-> sample_enable [*6])
    else $error("sampling phase too short");
  a_mux_follow: assert property (
    ctrl_wr |=> ##1 analog_mux_select == $past(reg_wdata[4:0], 2))
    else $error("channel not passed to mux");
  a_chan_off: assert property (
    ctrl_wr ##0 reg_wdata[4:0] == 5'h1f |=> ##1 analog_power_down)
    else $error("off code did not power down");
  a_trial_clear: assert property (
    sample_enable |-> sar_trial_code == 10'h000)
    else $error("trial code set while sampling");
endmodule

// >>> sim/analog_front_model.sv
// Purpose: Behavioural input mux and comparator beside the converter
// Assumes: Port channel n carries port_level plus n
// Notes:   Output wanders while powered down
`timescale 1ns/1ps
module analog_front_model (
  input  wire       clk,
  input  wire [9:0] port_level,
  input  wire [4:0] analog_mux_select,
  input  wire       analog_power_down,
  input  wire [9:0] sar_trial_code,
  output wire       comparator_out
);
  reg        noise = 1'b0;
  wire [9:0] level;
  assign level = analog_mux_select == 5'h1d ? 10'h3ff :
                 analog_mux_select == 5'h1e ? 10'h000 :
                 port_level + {5'h00, analog_mux_select};
  // Toggles so a powered-off result never looks plausible
  always @(posedge clk) noise <= ~noise;
  assign comparator_out = analog_power_down ? noise
                                            : level >= sar_trial_code;
endmodule

// >>> sim/tb.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Result checks run at divide 4 on bus clock, 64 cycles each
// Notes:   Crystal clock toggles every bus cycle
`timescale 1ns/1ps
module tb;
  reg        clk = 1'b0;
  reg        reset_n = 1'b0;
  reg  [1:0] reg_addr = 2'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_write = 1'b0;
  reg        reg_read = 1'b0;
  reg        crystal_clock = 1'b0;
  reg        stop_mode = 1'b0;
  reg  [9:0] port_level = 10'h000;
  wire [7:0] reg_rdata;
  wire       comparator_out, irq_request, analog_power_down, sample_enable;
  wire [4:0] analog_mux_select;
  wire [9:0] sar_trial_code;
  integer    failures = 0;
  integer    num_checks = 0;
  integer    m, c, n;
  reg  [9:0] a;
  reg  [4:0] ch;
  sar_adc_control_logic i_dut (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .crystal_clock(crystal_clock), .comparator_out(comparator_out),
    .stop_mode(stop_mode), .irq_request(irq_request),
    .analog_mux_select(analog_mux_select),
    .analog_power_down(analog_power_down),
    .sar_trial_code(sar_trial_code), .sample_enable(sample_enable));
  analog_front_model i_far (.clk(clk), .port_level(port_level),
    .analog_mux_select(analog_mux_select),
    .analog_power_down(analog_power_down),
    .sar_trial_code(sar_trial_code), .comparator_out(comparator_out));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) crystal_clock <= ~crystal_clock;
  task wr(input [1:0] ad, input [7:0] wd);
    begin
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= wd;
      @(posedge clk);
      reg_write <= 1'b0;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Read data is taken only in the cycle after the strobe
  task rdc(input [1:0] ad, input [7:0] exp);
    begin
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= ad;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  function [7:0] fmt(input [9:0] r, input [1:0] md, input hi);
    case (md)
      2'h0: fmt = hi ? 8'h00 : r[9:2];
      2'h1: fmt = hi ? {6'h00, r[9:8]} : r[7:0];
      default: fmt = hi ? {r[9] ^ md[0], r[8:2]} : {r[1:0], 6'h00};
    endcase
  endfunction
  initial begin
    repeat (5000) @(posedge clk);
    failures = failures + 1;
    conclude;
  end
  initial begin
    void'($urandom(32'h1c473353));
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    rdc(2'h0, 8'h1f);
    rdc(2'h3, 8'h04);
    // Throwaway conversion after leaving the off code
    wr(2'h0, 8'h00);
    repeat (70) @(posedge clk);
    // Every justification code on a random port channel; a tick of
    // four bus clocks lets the synchronised comparator settle
    for (m = 0; m < 4; m = m + 1) begin
      ch = 5'($urandom % 7);
      port_level <= 10'($urandom);
      wr(2'h3, {4'b0101, m[1:0], 2'b00});
      wr(2'h0, {3'b000, ch});
      repeat (70) @(posedge clk);
      a = port_level + {5'h00, ch};
      rdc(2'h0, {3'b100, ch});
      rdc(2'h1, fmt(a, m[1:0], 1'b1));
      rdc(2'h2, fmt(a, m[1:0], 1'b0));
      rdc(2'h0, {3'b000, ch});
    end
    // Continuous run with the low byte held by a high read
    wr(2'h3, 8'h54);
    port_level <= 10'($urandom);
    wr(2'h0, 8'h20);
    repeat (70) @(posedge clk);
    a = port_level;
    rdc(2'h1, fmt(a, 2'h1, 1'b1));
    port_level <= ~port_level;
    repeat (100) @(posedge clk);
    rdc(2'h2, fmt(a, 2'h1, 1'b0));
    repeat (40) @(posedge clk);
    rdc(2'h2, fmt(~a, 2'h1, 1'b0));
    wr(2'h0, 8'h1f);
    rdc(2'h0, 8'h1f);
    wr(2'h0, 8'h1d);
    repeat (70) @(posedge clk);
    // Interrupt on the high reference, then the other target
    wr(2'h0, 8'h5d);
    repeat (70) @(posedge clk);
    chk({7'h00, irq_request}, 8'h01);
    rdc(2'h0, 8'h5d);
    rdc(2'h1, 8'h03);
    chk({7'h00, irq_request}, 8'h00);
    rdc(2'h2, 8'hff);
    wr(2'h0, 8'hdd);
    repeat (70) @(posedge clk);
    chk({7'h00, irq_request}, 8'h00);
    // Stop in mid-conversion, then resume on ground
    wr(2'h0, 8'h1e);
    repeat (5) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (30) @(posedge clk);
    rdc(2'h0, 8'h1e);
    stop_mode <= 1'b0;
    repeat (70) @(posedge clk);
    rdc(2'h0, 8'h9e);
    // One settling conversion after stop before a result is trusted
    wr(2'h0, 8'h1e);
    repeat (70) @(posedge clk);
    rdc(2'h1, 8'h00);
    rdc(2'h2, 8'h00);
    // Prescale codes 0 to 4 and 7 on the bus clock; top bit set means 16
    for (c = 0; c < 6; c = c + 1) begin
      m = (c == 5) ? 7 : c;
      n = 1 << ((c == 5) ? 4 : c);
      wr(2'h3, {m[2:0], 5'b10100});
      wr(2'h0, 8'h00);
      repeat (16 * n - 4) @(posedge clk);
      rdc(2'h0, 8'h00);
      repeat (n + 6) @(posedge clk);
      rdc(2'h0, 8'h80);
    end
    // Crystal source at its reset selection
    wr(2'h3, 8'h04);
    wr(2'h0, 8'h00);
    repeat (24) @(posedge clk);
    rdc(2'h0, 8'h00);
    repeat (30) @(posedge clk);
    rdc(2'h0, 8'h80);
    conclude;
  end
endmodule
bind sar_adc_control_logic adc_ctrl_sva i_sva (.clk(clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .stop_mode(stop_mode), .irq_request(irq_request),
  .analog_mux_select(analog_mux_select),
  .analog_power_down(analog_power_down),
  .sar_trial_code(sar_trial_code), .sample_enable(sample_enable));
